// ---- floppy_cfg_pkg.sv ----
package floppy_cfg_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   // Printed offsets 0xf1 and 0xf2 are not multiples of four, so they are
   // kept as indices and the byte address is four times the index.
   localparam logic [7:0]  IDX_OUTPUT_CTRL   = 8'hf0;
   localparam logic [7:0]  IDX_DRIVE_OPTION  = 8'hf1;
   localparam logic [7:0]  IDX_DRIVE_TYPE    = 8'hf2;
   localparam logic [11:0] ADDR_OUTPUT_CTRL  = {2'h0, IDX_OUTPUT_CTRL, 2'h0};
   localparam logic [11:0] ADDR_DRIVE_OPTION = {2'h0, IDX_DRIVE_OPTION, 2'h0};
   localparam logic [11:0] ADDR_DRIVE_TYPE   = {2'h0, IDX_DRIVE_TYPE, 2'h0};

   // ----------------------------------------------------------------
   // Fields and reset values
   // ----------------------------------------------------------------
   localparam int          BIT_OUT_TYPE      = 6;
   localparam int          BIT_OUT_TRISTATE  = 7;
   localparam int          POS_DENSITY       = 2;
   localparam int          POS_BOOT          = 6;
   localparam logic [7:0]  OUTPUT_CTRL_MASK  = 8'hc0;
   localparam logic [7:0]  DRIVE_OPTION_MASK = 8'hcc;
   localparam logic [7:0]  RESET_OUTPUT_CTRL = 8'h00;
   localparam logic [7:0]  RESET_DRIVE_OPT   = 8'h00;
   localparam logic [7:0]  RESET_DRIVE_TYPE  = 8'h00;
   localparam int          NUM_DRIVES        = 4;
   localparam int          NUM_PINS          = 8;

   typedef enum logic [1:0] {
      DENS_NORMAL  = 2'h0,
      DENS_NORMAL1 = 2'h1,
      DENS_HIGH    = 2'h2,
      DENS_LOW     = 2'h3
   } density_e;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } apb_rsp_s;

   typedef struct packed {
      logic [NUM_PINS-1:0] out;
      logic [NUM_PINS-1:0] oe;
   } pin_drive_s;

endpackage : floppy_cfg_pkg

// ---- floppy_drive_config_regs.sv ----
// Notes on behaviour
// - Output type clear gives open-drain drive.
// - Output type set gives push-pull drive.
// - Output control set tri-states drive pins.
// - Parallel-port floppy pins ignore both bits.
// - Density field: normal, normal, force high, low.
// - Option bits 7:6 select boot drive.
// - Type register holds four two-bit drive types.
module floppy_drive_config_regs
   import floppy_cfg_pkg::*;
(
   input  wire logic                    clock,
   input  wire logic                    rstn,
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [11:0]             paddr,
   input  wire logic [31:0]             pwdata,
   input  wire logic [3:0]              pstrb,
   output logic      [31:0]             prdata,
   output logic                         pready,
   output logic                         pslverr,
   input  wire logic [NUM_PINS-1:0]     driveLevel,
   input  wire logic [NUM_PINS-1:0]     portLevel,
   input  wire logic                    densityNormal,
   output floppy_cfg_pkg::pin_drive_s   drivePins,
   output logic      [NUM_PINS-1:0]     portPins,
   output logic                         densityOut,
   output logic      [1:0]              bootDrive,
   output logic      [2*NUM_DRIVES-1:0] driveTypes
);
   import floppy_cfg_pkg::*;

   // ----------------------------------------------------------------
   // Registers and decode
   // ----------------------------------------------------------------
   logic [7:0] outputCtrl;
   logic [7:0] driveOption;
   logic [7:0] driveType;

   wire        setupPhase = psel & ~penable;
   wire        hitCtrl    = paddr == ADDR_OUTPUT_CTRL;
   wire        hitOption  = paddr == ADDR_DRIVE_OPTION;
   wire        hitType    = paddr == ADDR_DRIVE_TYPE;
   wire        hitAny     = hitCtrl | hitOption | hitType;
   wire        doWrite    = psel & penable & pready & pwrite & hitAny & pstrb[0];

   // Bits outside the masks are reserved and never stored, so they read zero.
   wire [7:0]  readByte   = hitCtrl   ? outputCtrl
                          : hitOption ? driveOption
                          : hitType   ? driveType
                          : 8'h00;

   // No wait state: the answer is registered in the setup cycle.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready  <= setupPhase;
         prdata  <= (setupPhase & ~pwrite) ? {24'h00_0000, readByte} : 32'h0000_0000;
         pslverr <= setupPhase & ~hitAny;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         outputCtrl  <= RESET_OUTPUT_CTRL;
         driveOption <= RESET_DRIVE_OPT;
         driveType   <= RESET_DRIVE_TYPE;
      end else if (doWrite) begin
         if (hitCtrl) begin
            outputCtrl <= pwdata[7:0] & OUTPUT_CTRL_MASK;
         end
         // Bits 1:0 are dropped, so a careless write of ones cannot stick.
         if (hitOption) begin
            driveOption <= pwdata[7:0] & DRIVE_OPTION_MASK;
         end
         if (hitType) begin
            driveType <= pwdata[7:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Drive outputs
   // ----------------------------------------------------------------
   density_e   densSel;
   assign densSel = density_e'(driveOption[POS_DENSITY +: 2]);

   function automatic logic densityLevel(input density_e sel, input logic normal);
      case (sel)
         DENS_HIGH: densityLevel = 1'b1;
         DENS_LOW:  densityLevel = 1'b0;
         default:   densityLevel = normal;
      endcase
   endfunction : densityLevel

   wire nextDensity = densityLevel(densSel, densityNormal);

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         densityOut <= 1'b0;
         bootDrive  <= 2'h0;
         driveTypes <= '0;
         portPins   <= '0;
      end else begin
         densityOut <= nextDensity;
         bootDrive  <= driveOption[POS_BOOT +: 2];
         driveTypes <= driveType;
         portPins   <= portLevel;
      end
   end

   floppy_pin_driver u_pins (
      .clock    (clock),
      .rstn     (rstn),
      .level    (driveLevel),
      .pushPull (outputCtrl[BIT_OUT_TYPE]),
      .tristate (outputCtrl[BIT_OUT_TRISTATE]),
      .pins     (drivePins)
   );

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   sequence s_write(logic [11:0] a);
      psel && penable && pready && pwrite && paddr == a && pstrb[0];
   endsequence

   a_tristate_pins: assert property (outputCtrl[BIT_OUT_TRISTATE] |=> drivePins.oe == '0)
      else $error("drive pins enabled while tri-stated");
   a_open_drain_low: assert property (!outputCtrl[BIT_OUT_TYPE] |=> drivePins.out == '0)
      else $error("open-drain pin drove high");
   a_push_pull_on: assert property (outputCtrl == 8'h40 |=> drivePins.oe == '1)
      else $error("push-pull pin not driven");
   a_port_passthru: assert property (rstn |=> portPins == $past(portLevel))
      else $error("parallel port pins altered");
   a_density_force: assert property (densSel == DENS_HIGH |=> densityOut)
      else $error("density not forced high");
   a_density_low: assert property (densSel == DENS_LOW |=> !densityOut)
      else $error("density not forced low");
   a_boot_select: assert property (s_write(ADDR_DRIVE_OPTION) ##2 1'b1
                                   |-> bootDrive == $past(pwdata[7:6], 2))
      else $error("boot drive mismatch");
   a_type_write: assert property (s_write(ADDR_DRIVE_TYPE) ##2 1'b1
                                  |-> driveTypes == $past(pwdata[7:0], 2))
      else $error("drive types mismatch");
   a_option_reserved: assert property (driveOption[1:0] == 2'h0)
      else $error("reserved option bits set");
   a_readback: assert property (s_write(ADDR_DRIVE_TYPE) ##1 (psel && !penable && !pwrite
                                && paddr == ADDR_DRIVE_TYPE)
                                |=> prdata[7:0] == $past(pwdata[7:0], 2))
      else $error("readback mismatch");

   // ----------------------------------------------------------------
   // Bus answer checks
   // ----------------------------------------------------------------
   // The answer is registered, so it must follow setup by exactly one edge
   // and fall again at once; a held pready would let a master take one
   // transfer twice.
   sequence s_setup_seen;
      rstn && psel && !penable;
   endsequence

   sequence s_access_write;
      rstn && psel && penable && pready && pwrite;
   endsequence

   sequence s_read_setup(logic [11:0] a);
      rstn && psel && !penable && !pwrite && paddr == a;
   endsequence

   a_ready_timing: assert property (s_setup_seen |=> pready)
      else $error("no ready after setup");
   a_ready_single: assert property (pready |=> !pready)
      else $error("ready held beyond one cycle");
   a_mapped_ok: assert property (s_setup_seen ##0 hitAny |=> !pslverr)
      else $error("error on mapped register");
   a_unmapped_error: assert property (s_setup_seen ##0 !hitAny
                                      |=> pslverr && prdata == 32'h0000_0000)
      else $error("unmapped access not refused");
   a_read_ctrl: assert property (s_read_setup(ADDR_OUTPUT_CTRL)
                                 |=> prdata == {24'h00_0000, $past(outputCtrl)})
      else $error("output control readback mismatch");
   a_read_option: assert property (s_read_setup(ADDR_DRIVE_OPTION)
                                   |=> prdata == {24'h00_0000, $past(driveOption)})
      else $error("drive option readback mismatch");

   // Anything refused must leave every register as it was.
   a_strobe_ignored: assert property (s_access_write ##0 !pstrb[0]
                                      |=> $stable(outputCtrl) && $stable(driveOption)
                                          && $stable(driveType))
      else $error("write without byte strobe landed");
   a_unmapped_write: assert property (s_access_write ##0 !hitAny
                                      |=> $stable(outputCtrl) && $stable(driveOption)
                                          && $stable(driveType))
      else $error("unmapped write landed");

   // ----------------------------------------------------------------
   // Pin and density checks
   // ----------------------------------------------------------------
   // Reset is part of the open-drain, push-pull and normal-density antecedents so the release edge starts no attempt.
   a_open_drain_oe: assert property (rstn && !outputCtrl[BIT_OUT_TYPE]
                                     && !outputCtrl[BIT_OUT_TRISTATE]
                                     |=> drivePins.oe == ~$past(driveLevel))
      else $error("open-drain enable mismatch");
   a_push_pull_out: assert property (rstn && outputCtrl[BIT_OUT_TYPE]
                                     && !outputCtrl[BIT_OUT_TRISTATE]
                                     |=> drivePins.out == $past(driveLevel)
                                         && drivePins.oe == '1)
      else $error("push-pull pin mismatch");
   a_tristate_write: assert property (s_write(ADDR_OUTPUT_CTRL)
                                      ##0 pwdata[BIT_OUT_TRISTATE]
                                      |=> ##1 drivePins.oe == '0)
      else $error("tri-state write did not release pins");
   a_density_normal: assert property (rstn && (densSel == DENS_NORMAL
                                      || densSel == DENS_NORMAL1)
                                      |=> densityOut == $past(densityNormal))
      else $error("density not passed through");
   a_density_write: assert property (s_write(ADDR_DRIVE_OPTION)
                                     ##0 pwdata[POS_DENSITY +: 2] == DENS_HIGH
                                     |=> ##1 densityOut)
      else $error("density write not forced high");

endmodule : floppy_drive_config_regs

// ---- floppy_drive_config_regs_tb.sv ----
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin errors++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module floppy_drive_config_regs_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import floppy_cfg_pkg::*;
   logic clock, rstn, psel, penable, pwrite, pready, pslverr, densityNormal, densityOut, rerr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdata;
   logic [3:0] pstrb;
   logic [7:0] driveLevel, portLevel, portPins, driveTypes, cable;
   logic [1:0] bootDrive;
   pin_drive_s drivePins;
   int errors = 0;
   int cmp_count = 0;
   floppy_drive_config_regs u_floppy_drive_config_regs (.clock(clock), .rstn(rstn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .driveLevel(driveLevel),
      .portLevel(portLevel), .densityNormal(densityNormal), .drivePins(drivePins),
      .portPins(portPins), .densityOut(densityOut), .bootDrive(bootDrive),
      .driveTypes(driveTypes));
   floppy_drive_model u_floppy_drive_model (.pins(drivePins), .cable(cable));
   // ------------------------------------------------
   // Bus master and helpers
   // ------------------------------------------------
   // Waits in the access phase until pready is sampled high; a slave that
   // never answers counts as a mismatch.
   task automatic await_ready();
      int n;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         errors++;
      end
      rdata = prdata;
      rerr  = pslverr;
   endtask : await_ready
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s);
      @(posedge clock);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      pstrb   <= s;
      @(posedge clock);
      penable <= 1'b1;
      await_ready();
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic summarize();
      if (errors == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : summarize
   // ------------------------------------------------
   // Scenarios
   // ------------------------------------------------
   task automatic t_reset_open_drain();
      apb(1'b0, ADDR_DRIVE_TYPE, 32'h0, 4'hf);
      `CHK(rdata, 32'h0)
      `CHK(bootDrive, 2'h0)
      driveLevel <= 8'h5a;
      repeat (3) @(posedge clock);
      `CHK(drivePins.oe, 8'ha5)
      `CHK(cable, 8'h5a)
   endtask : t_reset_open_drain
   task automatic t_push_tristate();
      apb(1'b1, ADDR_OUTPUT_CTRL, 32'h40, 4'hf);
      repeat (3) @(posedge clock);
      `CHK(drivePins, {8'h5a, 8'hff})
      `CHK(cable, 8'h5a)
      apb(1'b1, ADDR_OUTPUT_CTRL, 32'hc7, 4'hf);
      apb(1'b0, ADDR_OUTPUT_CTRL, 32'h0, 4'hf);
      `CHK(rdata, 32'hc0)
      portLevel <= 8'h3c;
      repeat (3) @(posedge clock);
      `CHK(drivePins.oe, 8'h00)
      `CHK(cable, 8'hff)
      `CHK(portPins, 8'h3c)
      apb(1'b1, ADDR_OUTPUT_CTRL, 32'h0, 4'hf);
   endtask : t_push_tristate
   task automatic t_option();
      logic [1:0] v;
      for (int i = 0; i < 4; i++) begin
         v = i[1:0];
         densityNormal <= v[0];
         // Low bits stay zero as software must write them so.
         apb(1'b1, ADDR_DRIVE_OPTION, {24'h0, v, 2'h3, v, 2'h0}, 4'hf);
         apb(1'b0, ADDR_DRIVE_OPTION, 32'h0, 4'hf);
         `CHK(rdata, {24'h0, v, 2'h0, v, 2'h0})
         repeat (3) @(posedge clock);
         `CHK(bootDrive, v)
         `CHK(densityOut, (v == 2'h0 || v == 2'h2)  ? (v == 2'h2) : (v == 2'h1))
      end
   endtask : t_option
   task automatic t_type_unmapped();
      apb(1'b1, ADDR_DRIVE_TYPE, 32'he4, 4'hf);
      apb(1'b1, ADDR_DRIVE_TYPE, 32'h1b, 4'h0);
      apb(1'b1, 12'h3cc, 32'hff, 4'hf);
      `CHK(rerr, 1'b1)
      apb(1'b0, ADDR_DRIVE_TYPE, 32'h0, 4'hf);
      `CHK(rdata, 32'he4)
      repeat (3) @(posedge clock);
      `CHK(driveTypes, 8'he4)
      apb(1'b0, 12'h3cc, 32'h0, 4'hf);
      `CHK({rerr, rdata}, 33'h100000000)
   endtask : t_type_unmapped
   // Write and read back with the read setup straight after the write access.
   task automatic t_back_to_back();
      @(posedge clock);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= 1'b1;
      paddr   <= ADDR_DRIVE_TYPE;
      pwdata  <= 32'h0000_0093;
      pstrb   <= 4'hf;
      @(posedge clock);
      penable <= 1'b1;
      await_ready();
      penable <= 1'b0;
      pwrite  <= 1'b0;
      @(posedge clock);
      penable <= 1'b1;
      await_ready();
      psel    <= 1'b0;
      penable <= 1'b0;
      `CHK(rdata, 32'h0000_0093)
      `CHK(rerr, 1'b0)
      repeat (3) @(posedge clock);
      `CHK(driveTypes, 8'h93)
   endtask : t_back_to_back
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   initial begin
      #200000;
      errors++;
      summarize();
   end
   initial begin
      rstn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0;
      pwdata = 32'h0; pstrb = 4'h0; driveLevel = 8'h0; portLevel = 8'h0; densityNormal = 1'b0;
      repeat (3) @(posedge clock);
      rstn <= 1'b1;
      t_reset_open_drain();
      t_push_tristate();
      t_option();
      t_type_unmapped();
      t_back_to_back();
      summarize();
   end
endmodule : floppy_drive_config_regs_tb

// ---- floppy_drive_model.sv ----
module floppy_drive_model
   import floppy_cfg_pkg::*;
(
   input  wire floppy_cfg_pkg::pin_drive_s pins,
   output logic [NUM_PINS-1:0]             cable
);
   import floppy_cfg_pkg::*;
   // ------------------------------------------------
   // Cable termination
   // ------------------------------------------------
   // Each line has a pull-up, so a line nobody drives reads high.
   for (genvar i = 0; i < NUM_PINS; i++) begin : g_line
      assign cable[i] = pins.oe[i] ? pins.out[i] : 1'b1;
   end
endmodule : floppy_drive_model

// ---- floppy_pin_driver.sv ----
module floppy_pin_driver
   import floppy_cfg_pkg::*;
(
   input  wire logic                clock,
   input  wire logic                rstn,
   input  wire logic [NUM_PINS-1:0] level,
   input  wire logic                pushPull,
   input  wire logic                tristate,
   output floppy_cfg_pkg::pin_drive_s pins
);

   // ----------------------------------------------------------------
   // Per-pin buffer shaping
   // ----------------------------------------------------------------
   // Open-drain pulls low only; the cable pull-up gives the high level.
   logic [NUM_PINS-1:0] nextOut;
   logic [NUM_PINS-1:0] nextOe;

   for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
      assign nextOut[i] = pushPull ? level[i] : 1'b0;
      assign nextOe[i]  = tristate ? 1'b0 : (pushPull | ~level[i]);
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         pins <= '0;
      end else begin
         pins <= '{out: nextOut, oe: nextOe};
      end
   end

endmodule : floppy_pin_driver
